/* burst_sram_pkg.sv */
// Shared constants and types for the pipelined burst cache SRAM
package burst_sram_pkg;

    // ********************************************************
    // Array geometry
    // ********************************************************
    localparam int ADDR_W  = 15;
    localparam int DATA_W  = 18;
    localparam int DEPTH   = 32768;
    localparam int LANE_W  = 9;
    localparam int LO_LSB  = 0;
    localparam int HI_LSB  = 9;
    localparam int BURST_W = 2;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [1:0]  BURST_RST = 2'h0;
    localparam logic [17:0] DATA_RST  = 18'h00000;

    // ********************************************************
    // Access kinds registered on each edge
    // ********************************************************
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_READ,
        ACC_WRITE
    } access_t;

endpackage : burst_sram_pkg

/* sram_array.sv */
// Byte-lane writable storage array with a combinational read port
module sram_array
    import burst_sram_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W,
    parameter int LW = LANE_W
) (
    // Clock
    input  wire logic          mclk,
    // Write port
    input  wire logic          wr_lo,
    input  wire logic          wr_hi,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // Read port
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Lane writes land on the clock edge, no external pulse shaping
    always_ff @(posedge mclk) begin
        if (wr_lo) begin
            mem[wr_addr][LW-1:0] <= wr_data[LW-1:0];
        end
        if (wr_hi) begin
            mem[wr_addr][DW-1:LW] <= wr_data[DW-1:LW];
        end
    end

    // Read data is raw array content, looked up within the cycle so the
    // caller's single output register gives the one-edge pipeline
    always_comb begin
        rd_data = '0;
        if (rd_en) begin
            rd_data = mem[rd_addr];
        end
    end

endmodule : sram_array

/* burst_cache_sram.sv */
// Pipelined burst cache SRAM core with byte writes and write pass-through
module burst_cache_sram
    import burst_sram_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          nrst,
    // Address and burst control
    input  wire logic [AW-1:0] word_addr,
    input  wire logic          proc_addr_strobe_n,
    input  wire logic          ctrl_addr_strobe_n,
    input  wire logic          burst_advance_n,
    input  wire logic          chip_en_n,
    // Byte write enables
    input  wire logic          low_byte_wr_n,
    input  wire logic          high_byte_wr_n,
    // Asynchronous output enable
    input  wire logic          out_en_n,
    // Data pins, split into three signals
    input  wire logic [DW-1:0] data_i,
    output logic      [DW-1:0] data_o,
    output logic               data_oe
);

    // ********************************************************
    // Helpers
    // ********************************************************

    // Interleaved burst order is a plain xor of the step count onto the base
    function automatic logic [1:0] burst_low(input logic [1:0] base, input logic [1:0] step);
        burst_low = base ^ step;
    endfunction : burst_low

    // ********************************************************
    // Input registers
    // ********************************************************
    logic          new_base;
    logic          is_write_in;
    logic [AW-1:0] base_q;
    logic [1:0]    step_q;
    logic          sel_q;
    logic [AW-1:0] acc_addr_q;
    access_t       acc_q;
    logic          acc_lo_q;
    logic          acc_hi_q;
    logic [DW-1:0] wdata_q;

    // strobe priority: processor strobe wins and forces read
    assign new_base    = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
    // either lane enable low marks a write
    assign is_write_in = proc_addr_strobe_n && (!low_byte_wr_n || !high_byte_wr_n);

    // chip enable captured only when a new base loads
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sel_q <= 1'b0;
        end else if (new_base) begin
            sel_q <= !chip_en_n;
        end
    end

    // upper bits fixed, low two bits walk the burst
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            base_q <= '0;
            step_q <= BURST_RST;
        end else if (new_base) begin
            // any strobe abandons the burst and reloads base
            base_q <= word_addr;
            step_q <= BURST_RST;
        end else if (!burst_advance_n) begin
            // two-bit counter wraps naturally after four
            step_q <= step_q + 2'h1;
        end
    end

    // registered access address, kind, lanes and write data
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            acc_addr_q <= '0;
            acc_q      <= ACC_IDLE;
            acc_lo_q   <= 1'b0;
            acc_hi_q   <= 1'b0;
            wdata_q    <= DATA_RST;
        end else begin
            wdata_q  <= data_i;
            acc_lo_q <= !low_byte_wr_n;
            acc_hi_q <= !high_byte_wr_n;
            if (new_base) begin
                acc_addr_q <= word_addr;
                // deselected cycle does no array access
                if (chip_en_n) begin
                    acc_q <= ACC_IDLE;
                end else if (is_write_in) begin
                    acc_q <= ACC_WRITE;
                end else begin
                    acc_q <= ACC_READ;
                end
            end else begin
                // advance low steps before the access
                // advance high repeats the current address
                acc_addr_q <= {base_q[AW-1:BURST_W],
                               burst_low(base_q[1:0],
                                         burst_advance_n ? step_q : step_q + 2'h1)};
                if (!sel_q) begin
                    acc_q <= ACC_IDLE;
                end else if (!low_byte_wr_n || !high_byte_wr_n) begin
                    acc_q <= ACC_WRITE;
                end else begin
                    acc_q <= ACC_READ;
                end
            end
        end
    end

    // ********************************************************
    // Array and pass-through
    // ********************************************************
    logic          wr_lo;
    logic          wr_hi;
    logic          rd_en;
    logic [DW-1:0] array_q;
    logic          next_wr;
    logic [DW-1:0] merged;

    // write committed on the edge after capture
    assign wr_lo = (acc_q == ACC_WRITE) && acc_lo_q;
    assign wr_hi = (acc_q == ACC_WRITE) && acc_hi_q;
    // Any live access looks its word up; a write needs the old word for
    // the lane it leaves untouched when the word is passed through
    assign rd_en = (acc_q != ACC_IDLE);

    sram_array #(
        .AW (AW),
        .DW (DW),
        .LW (LANE_W)
    ) u_array (
        .mclk    (mclk),
        .wr_lo   (wr_lo),
        .wr_hi   (wr_hi),
        .wr_addr (acc_addr_q),
        .wr_data (wdata_q),
        .rd_en   (rd_en),
        .rd_addr (acc_addr_q),
        .rd_data (array_q)
    );

    // the cycle now on the pins is no write, so the bus is free to
    // show the word just written in the output slot of that write
    assign next_wr = proc_addr_strobe_n && (!low_byte_wr_n || !high_byte_wr_n);

    // written lanes laid over the stored word
    always_comb begin
        merged = array_q;
        if (acc_lo_q) begin
            merged[LANE_W-1:0] = wdata_q[LANE_W-1:0];
        end
        if (acc_hi_q) begin
            merged[DW-1:LANE_W] = wdata_q[DW-1:LANE_W];
        end
    end

    // ********************************************************
    // Output register and drivers
    // ********************************************************
    logic rd_valid_q;

    // output stage holds the access registered one edge earlier
    // pass-through needs no chip enable on the following cycle
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= (acc_q == ACC_READ) || ((acc_q == ACC_WRITE) && !next_wr);
        end
    end

    // Output data register; idle cycles hold the last word
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            data_o <= DATA_RST;
        end else if (acc_q == ACC_READ) begin
            data_o <= array_q;
        end else if (acc_q == ACC_WRITE) begin
            data_o <= merged;
        end
    end

    // OE is combinational; drive on reads and on write pass-through
    // a reset edge leaves the pins floating; rd_valid_q has no power-up value
    // Limitation: one enable covers both lanes, so a single-lane pass-through
    // drives the untouched lane from the array as well
    assign data_oe = rd_valid_q && !out_en_n;

endmodule : burst_cache_sram

/* burst_sram_asserts.sv */
// Port-level assertion checker for the burst cache SRAM core
module burst_sram_asserts
    import burst_sram_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    // Clock, reset and control
    input wire logic mclk, nrst, proc_addr_strobe_n, ctrl_addr_strobe_n,
    input wire logic burst_advance_n, chip_en_n, low_byte_wr_n, high_byte_wr_n,
    input wire logic out_en_n, data_oe,
    // Address and data
    input wire logic [AW-1:0] word_addr,
    input wire logic [DW-1:0] data_i, data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic pr, cw, cr, rd;
    // Selected processor load, controller write and controller read
    assign pr = !proc_addr_strobe_n && !chip_en_n;
    assign rd = low_byte_wr_n && high_byte_wr_n;
    assign cw = proc_addr_strobe_n && !ctrl_addr_strobe_n && !chip_en_n && !rd;
    assign cr = proc_addr_strobe_n && !ctrl_addr_strobe_n && !chip_en_n && rd;
    a_oe_enable: assert property (out_en_n |-> !data_oe)
        else $error("driving with enable high");
    a_oe_reset: assert property (disable iff (1'b0) !nrst |=> !data_oe)
        else $error("driving after reset");
    a_proc_read: assert property (pr |-> ##2 (data_oe == !out_en_n))
        else $error("processor read not driven");
    a_ctrl_read: assert property (cr |-> ##2 (data_oe == !out_en_n))
        else $error("controller read not driven");
    a_write_float: assert property (cw ##1 (proc_addr_strobe_n && !rd) |-> ##1 !data_oe)
        else $error("driving during write");
    a_desel_float: assert property (!proc_addr_strobe_n && chip_en_n |-> ##2 !data_oe)
        else $error("deselect drove bus");
    a_ce_ignored: assert property (pr ##1 (proc_addr_strobe_n && ctrl_addr_strobe_n
        && chip_en_n && rd) |-> ##2 (data_oe == !out_en_n))
        else $error("burst dropped by enable");
    a_write_forward: assert property ((cw && !low_byte_wr_n && !high_byte_wr_n) ##1
        (pr && word_addr == $past(word_addr)) |-> ##2 (data_o == $past(data_i, 3)))
        else $error("written word not forwarded");
    a_pass_drive: assert property (cw ##1 !proc_addr_strobe_n |-> ##1 (data_oe == !out_en_n))
        else $error("pass-through not driven");
endmodule : burst_sram_asserts

/* cache_bus_model.sv */
// Bus-side model of the processor and cache controller
module cache_bus_model
    import burst_sram_pkg::*;
(
    // Pins toward the memory
    output logic [ADDR_W-1:0] word_addr,
    output logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, chip_en_n,
    output logic low_byte_wr_n, high_byte_wr_n, out_en_n,
    output logic [DATA_W-1:0] data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Pin driver
    // ****************
    // chip enable valid on every edge
    task automatic drive(input logic [6:0] c, input logic [14:0] a, input logic [17:0] d);
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, chip_en_n,
         low_byte_wr_n, high_byte_wr_n, out_en_n} = c;
        // enable high while write data shown
        if (!c[2] || !c[1]) out_en_n = 1'b1;
        word_addr = a;
        // Idle pins toggle so a stale level never passes
        data_i = (c[2] && c[1]) ? ~data_i : d;
    endtask : drive
    initial begin
        data_i = 18'h00000;
        drive(7'h7f, 15'h0000, 18'h00000);
    end
endmodule : cache_bus_model

/* tb_burst_cache_sram.sv */
// Self-checking bench for the burst cache SRAM core
module tb_burst_cache_sram
    import burst_sram_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Wiring and model
    // ****************
    typedef struct packed {logic rd; logic [17:0] d;} exp_t;
    typedef struct packed {logic [6:0] c; logic [14:0] a; logic [17:0] d;} row_t;
    localparam logic [6:0] IDLE = 7'h7f, SUSP = 7'h7e, BURST_ADVANCE_N = 7'h6e, AWR = 7'h61;
    localparam row_t ROWS [20] = '{
        {7'h51, 15'h1236, 18'h2a5a5}, {AWR, 15'h0, 18'h15a5a}, {AWR, 15'h0, 18'h3c3c3},
        {AWR, 15'h0, 18'h0f0f0}, {7'h36, 15'h1237, 18'h0}, {BURST_ADVANCE_N, 15'h0, 18'h0},
        {BURST_ADVANCE_N, 15'h0, 18'h0}, {SUSP, 15'h0, 18'h0}, {BURST_ADVANCE_N, 15'h0, 18'h0},
        {BURST_ADVANCE_N, 15'h0, 18'h0}, {7'h53, 15'h1234, 18'h3ffff}, {7'h56, 15'h1234, 18'h0},
        {7'h51, 15'h0100, 18'h12345}, {7'h36, 15'h0100, 18'h0}, {7'h3e, 15'h0100, 18'h0},
        {7'h30, 15'h1236, 18'h0}, {7'h36, 15'h1236, 18'h0}, {SUSP, 15'h0, 18'h0},
        {SUSP, 15'h0, 18'h0}, {SUSP, 15'h0, 18'h0}};
    logic mclk, nrst, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, chip_en_n;
    logic low_byte_wr_n, high_byte_wr_n, out_en_n, data_oe, sel;
    logic [ADDR_W-1:0] word_addr, base;
    logic [DATA_W-1:0] data_i, data_o;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [1:0] stp;
    logic last_wr = 1'b0;
    exp_t pipe [$];
    int err_total = 0;
    int samples_checked = 0;
    burst_cache_sram uut (.*);
    cache_bus_model pm (.*);
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic cmp(input string nm, input logic [17:0] ev, input logic [17:0] got);
        samples_checked++;
        if (got !== ev) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ev, got);
        end
    endtask : cmp
    // One cycle: check the answer two edges back, drive, predict
    task automatic step(input logic [6:0] c, input logic [14:0] a, input logic [17:0] d);
        exp_t e;
        logic wr;
        logic [14:0] ad;
        @(posedge mclk);
        #1;
        // Reset clears the output stage, so nothing in flight is owed
        if (!nrst) begin
            foreach (pipe[i]) pipe[i].rd = 1'b0;
        end
        if (pipe.size() == 2) begin
            e = pipe.pop_front();
            cmp("oe", {17'h0, e.rd && !out_en_n}, {17'h0, data_oe});
            if (e.rd && !out_en_n) cmp("data", e.d, data_o);
        end
        pm.drive(c, a, d);
        wr = !low_byte_wr_n || !high_byte_wr_n;
        // a non-write right after a write shows the written word
        if (nrst && last_wr && !(proc_addr_strobe_n && wr)) pipe[$].rd = 1'b1;
        if (!proc_addr_strobe_n || !ctrl_addr_strobe_n) begin
            base = a;
            stp = 2'h0;
            sel = !chip_en_n;
            wr = wr && proc_addr_strobe_n;
        end else if (!burst_advance_n) begin
            stp = stp + 2'h1;
        end
        if (!nrst) sel = 1'b0;
        last_wr = sel && wr;
        ad = {base[14:2], base[1:0] ^ stp};
        if (sel && wr && !low_byte_wr_n) mem[ad][LO_LSB+:LANE_W] = data_i[LO_LSB+:LANE_W];
        if (sel && wr && !high_byte_wr_n) mem[ad][HI_LSB+:LANE_W] = data_i[HI_LSB+:LANE_W];
        e.rd = sel && !wr;
        e.d = mem[ad];
        pipe.push_back(e);
    endtask : step
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // ****************
    // Sequence
    // ****************
    initial begin
        nrst = 1'b0;
        sel = 1'b0;
        repeat (20) step(IDLE, 15'h0, 18'h0);
        cmp("reset data", DATA_RST, data_o);
        nrst = 1'b1;
        foreach (ROWS[i]) step(ROWS[i].c, ROWS[i].a, ROWS[i].d);
        // Reset in mid-burst silences the drivers
        nrst = 1'b0;
        repeat (3) step(IDLE, 15'h0, 18'h0);
        cmp("reset oe", 18'h0, {17'h0, data_oe});
        tally_and_finish();
    end
    // Hang guard
    initial begin
        repeat (2000) @(posedge mclk);
        err_total++;
        tally_and_finish();
    end
endmodule : tb_burst_cache_sram
bind burst_cache_sram burst_sram_asserts #(.AW(AW), .DW(DW)) chk (.*);
